// ===== srs_top.sv
// System reset sequencer, bus clock divider and reset cause register.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// Function
// RULE_01 - Bus clock enable runs at one quarter of the selected source clock.
// RULE_02 - Power-on or undervoltage holds clocks off and pin low for 4096 cycles.
// RULE_03 - Every reset asserts internal reset and selects user or monitor vector pair.
// RULE_04 - Internal reset returns all registers and modules to default state.
// RULE_05 - Internal resets clear the system counter; pin reset leaves it alone.
// RULE_06 - Each reset source sets its own cause flag.
// RULE_07 - Pin flag set only after 67 low cycles without power-on or undervoltage.
// RULE_08 - Internal sources drive pin low 32 cycles, then internal reset 32 more.
// RULE_09 - Power-on: pin low for 4096 cycles, release CPU 64 cycles later.
// RULE_10 - Power-on enables clock output, asserts reset, sets only power-on flag.
// RULE_11 - Watchdog timeout input is taken asynchronously and synchronised.
// RULE_12 - Watchdog overflow performs internal reset with pin pull-down and flag.
// RULE_13 - Write to top address clears watchdog and system counter bits 12 to 4.
// RULE_14 - System counter overflow clocks the watchdog counter.
// RULE_15 - Watchdog disabled only by combinational high-voltage pin conditions.
// RULE_16 - Undefined or stop opcodes set bad-opcode flag and reset; the code treats a stop opcode as bad only when big_part is high.
// RULE_17 - Opcode fetch from unmapped space sets bad-address flag and resets.
// RULE_18 - Erased reset vector causes reset, then forces monitor operation.
// RULE_19 - Undervoltage for nine CPU cycles sets flag and runs 4096 plus 64 sequence.
// RULE_20 - Wait mode stops CPU clock enable while peripheral clocks keep running.
// RULE_21 - System counter is 13 bits and free runs after every reset.
// RULE_22 - Reading the cause register clears all cause flags.
// RULE_23 - Reset pin passes a two-stage synchroniser before its low time is counted.
module srs_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic por_pulse,
	input wire logic uv_low,
	input wire logic wdg_timeout,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_b,
	input wire logic pll_sel,
	input wire logic pll_clk_en,
	input wire logic hv_rst_pin,
	input wire logic hv_irq_pin,
	input wire logic mon_mode,
	input wire logic break_state,
	input wire logic big_part,
	input wire srs_pkg::srs_cpu_s cpu,
	output logic internal_reset,
	output logic cpu_clk_en,
	output logic per_clk_en,
	output logic clk_gen_en,
	output logic force_monitor,
	output logic [15:0] reset_vector,
	output logic wdg_disable,
	output logic [12:0] sys_count,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	import srs_pkg::*;

	// ****************************************************************
	// Input synchronisers.
	// ****************************************************************
	logic [1:0] pin_s_r;
	logic [1:0] wdg_s_r;
	logic [1:0] uv_s_r;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_s_r <= 2'h3;
			wdg_s_r <= 2'h0;
			uv_s_r <= 2'h0;
		end
		else
		begin
			pin_s_r <= {pin_s_r[0], rst_pin_i}; // RULE_23
			wdg_s_r <= {wdg_s_r[0], wdg_timeout}; // RULE_11
			uv_s_r <= {uv_s_r[0], uv_low};
		end
	end
	wire pin_low = !pin_s_r[1];
	wire wdg_in = wdg_s_r[1];
	wire uv_in = uv_s_r[1];

	// ****************************************************************
	// Bus clock divider.
	// ****************************************************************
	logic [1:0] div_r;
	logic bus_tick;
	wire src_tick = pll_sel ? pll_clk_en : 1'b1;
	assign bus_tick = src_tick && (div_r == 2'(BUS_DIV - 1)); // RULE_01
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			div_r <= 2'h0;
		else if (src_tick)
			div_r <= div_r + 2'h1;
	end

	// ****************************************************************
	// Reset sources.
	// ****************************************************************
	srs_state_e st_r;
	logic [3:0] uv_cnt_r;
	logic [6:0] pin_cnt_r;
	logic [12:0] seq_r;
	logic [7:0] cause_r;
	logic [7:0] wdg_cnt;
	logic por_seen_r;
	logic wdg_prev_r;
	logic mon_force_r;
	logic sc_wrap;
	logic wdg_wrap;
	wire busy = (st_r != SRS_IDLE);
	wire uv_trip = uv_in && (uv_cnt_r >= 4'(LVI_CPU_CYC)); // RULE_19
	wire wdg_edge = wdg_in && !wdg_prev_r;
	assign wdg_disable = (mon_mode && (hv_rst_pin || hv_irq_pin)) || (break_state && hv_rst_pin); // RULE_15
	wire opc_bad = cpu.opfetch && (cpu.illegal_op || (cpu.stop_op && big_part)); // RULE_16
	wire adr_bad = cpu.opfetch && !cpu.mapped; // RULE_17
	wire blk_bad = cpu.vecfetch && (cpu.data == ERASED_BYTE); // RULE_18
	wire wdg_bad = (wdg_edge || wdg_wrap) && !wdg_disable; // RULE_12
	wire int_src = !busy && (opc_bad || adr_bad || blk_bad || wdg_bad);
	wire svc_wr = cpu.wr && (cpu.addr == WDG_SVC_ADDR) && !busy;
	wire pin_start = !busy && pin_low;
	wire pwr_start = por_pulse || (uv_trip && !(st_r == SRS_STAB && cause_r[F_LVI]));
	wire cause_rd = reg_rd && (reg_addr == REG_CAUSE);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			uv_cnt_r <= 4'h0;
			wdg_prev_r <= 1'b0;
		end
		else
		begin
			wdg_prev_r <= wdg_in;
			if (!uv_in)
				uv_cnt_r <= 4'h0;
			else if (bus_tick && uv_cnt_r < 4'(LVI_CPU_CYC))
				uv_cnt_r <= uv_cnt_r + 4'h1;
		end
	end

	// ****************************************************************
	// System counter and watchdog counter.
	// ****************************************************************
	wire sc_clr = pwr_start || int_src; // RULE_05
	srs_cnt #(.W(SCNT_W)) u_sys_cnt (
		.clk(clk),
		.rst_b(rst_b),
		.en(1'b1), // RULE_21
		.clr(sc_clr),
		.keep_mask(SCNT_SVC_MASK),
		.pclr(svc_wr), // RULE_13
		.cnt(sys_count),
		.wrap(sc_wrap)
	);
	srs_cnt #(.W(WDG_W)) u_wdg_cnt (
		.clk(clk),
		.rst_b(rst_b),
		.en(sc_wrap && !internal_reset && !wdg_disable), // RULE_14
		.clr(svc_wr || internal_reset), // RULE_13
		.keep_mask('0),
		.pclr(1'b0),
		.cnt(wdg_cnt),
		.wrap(wdg_wrap)
	);

	// ****************************************************************
	// Reset sequencer.
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r <= SRS_STAB;
			seq_r <= 13'h0;
			pin_cnt_r <= 7'h0;
			por_seen_r <= 1'b1;
			mon_force_r <= 1'b0;
		end
		else if (pwr_start)
		begin
			st_r <= SRS_STAB; // RULE_02
			seq_r <= 13'h0;
			por_seen_r <= 1'b1;
		end
		else
		begin
			unique case (st_r)
				SRS_IDLE:
				begin
					seq_r <= 13'h0;
					pin_cnt_r <= 7'h0;
					por_seen_r <= 1'b0;
					if (int_src)
					begin
						st_r <= SRS_PDRV; // RULE_08
						mon_force_r <= mon_force_r || blk_bad; // RULE_18
					end
					else if (pin_start)
						st_r <= SRS_EXTP;
				end
				SRS_STAB:
				begin
					seq_r <= seq_r + 13'h1;
					if (seq_r == 13'(STAB_CYC - 1))
					begin
						st_r <= SRS_IEXT; // RULE_09
						seq_r <= 13'(INTERNAL_RESET_EXT_CYC + INTERNAL_RESET_EXT_CYC - POR_REL_CYC);
					end
				end
				SRS_PDRV:
				begin
					seq_r <= seq_r + 13'h1;
					if (seq_r == 13'(PIN_DRV_CYC - 1))
					begin
						st_r <= SRS_IEXT;
						seq_r <= 13'(INTERNAL_RESET_EXT_CYC);
					end
				end
				SRS_IEXT:
				begin
					seq_r <= seq_r + 13'h1;
					if (seq_r == 13'(INTERNAL_RESET_EXT_CYC + INTERNAL_RESET_EXT_CYC - 1))
						st_r <= SRS_IDLE;
				end
				SRS_EXTP:
				begin
					if (pin_low && pin_cnt_r != 7'(PIN_QUAL_CYC))
						pin_cnt_r <= pin_cnt_r + 7'h1; // RULE_07
					if (!pin_low)
						st_r <= SRS_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Reset cause register.
	// ****************************************************************
	logic [7:0] set_v;
	always_comb
	begin
		set_v = 8'h00;
		set_v[F_WDG] = int_src && wdg_bad && !opc_bad && !adr_bad && !blk_bad;
		set_v[F_OPC] = int_src && opc_bad;
		set_v[F_ADR] = int_src && adr_bad && !opc_bad;
		set_v[F_BLK] = int_src && blk_bad && !opc_bad && !adr_bad;
		set_v[F_PIN] = (st_r == SRS_EXTP) && !por_seen_r
			&& (pin_cnt_r == 7'(PIN_QUAL_CYC - 1)) && pin_low; // RULE_07
		set_v[F_LVI] = uv_trip && !por_pulse; // RULE_19
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cause_r <= CAUSE_RST; // RULE_10
		else if (por_pulse)
			cause_r <= CAUSE_RST; // RULE_10
		else
			cause_r <= (cause_rd ? 8'h00 : cause_r) | set_v; // RULE_06 RULE_22
	end

	// ****************************************************************
	// Outputs and register reads.
	// ****************************************************************
	wire pin_drive = (st_r == SRS_STAB) || (st_r == SRS_PDRV); // RULE_08
	assign rst_pin_o = 1'b0;
	assign rst_pin_oe_b = !pin_drive;
	assign internal_reset = busy; // RULE_03 RULE_04
	assign clk_gen_en = 1'b1; // RULE_10
	assign per_clk_en = bus_tick && (st_r != SRS_STAB); // RULE_02
	assign cpu_clk_en = per_clk_en && !busy && !cpu.wait_mode; // RULE_20
	assign force_monitor = mon_force_r;
	assign reset_vector = (mon_mode || mon_force_r) ? VEC_HI_MON : VEC_HI_USER; // RULE_03

	logic [7:0] rdata_r;
	logic [7:0] rd_mux;
	assign rd_mux = (reg_addr == REG_CAUSE) ? cause_r
		: (reg_addr == REG_CTRL) ? {7'h0, mon_force_r}
		: (reg_addr == REG_STAT) ? wdg_cnt : 8'h00;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata_r <= 8'h00;
		else
			rdata_r <= reg_rd ? rd_mux : 8'h00;
	end
	assign reg_rdata = rdata_r;
	wire unused_wdata = ^reg_wdata ^ reg_wr;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_idle_int;
		(st_r == SRS_IDLE) && int_src && !pwr_start;
	endsequence
	sequence s_iext_last;
		(st_r == SRS_IEXT) && (seq_r == 13'(INTERNAL_RESET_EXT_CYC + INTERNAL_RESET_EXT_CYC - 1)) && !pwr_start;
	endsequence
	a_pin_drive_len: assert property (s_idle_int |=> (!rst_pin_oe_b)[*8]) // RULE_08
		else $error("pin not driven after internal reset");
	a_internal_reset_after_pin: assert property (s_idle_int |-> ##32 internal_reset) // RULE_08
		else $error("internal reset dropped early");
	a_por_stab: assert property (por_pulse |=> (st_r == SRS_STAB) && !per_clk_en) // RULE_02
		else $error("clocks not held after power-on");
	a_por_flag: assert property (por_pulse |=> cause_r == CAUSE_RST) // RULE_10
		else $error("power-on flag wrong");
	a_rd_clears: assert property (cause_rd && set_v == 8'h00 && !por_pulse |=> cause_r == 8'h00) // RULE_22
		else $error("cause read did not clear");
	a_wdg_flag: assert property (int_src && set_v[F_WDG] && !por_pulse |=> cause_r[F_WDG]) // RULE_06
		else $error("watchdog flag not set");
	a_cpu_wait: assert property (cpu.wait_mode |-> !cpu_clk_en) // RULE_20
		else $error("cpu clock in wait");
	a_sc_clear: assert property (sc_clr |=> sys_count == 13'h0) // RULE_05
		else $error("system counter not cleared");
	a_svc_keep: assert property (svc_wr && !sc_clr |=> sys_count[12:4] == 9'h0) // RULE_13
		else $error("service write did not clear counter");
	a_bus_div: assert property (bus_tick && !pll_sel |=> !bus_tick[*3]) // RULE_01
		else $error("bus tick too often");
	a_iext_end: assert property (s_iext_last |=> !internal_reset && rst_pin_oe_b) // RULE_08
		else $error("internal reset not released after extension");
	a_stab_end: assert property ((st_r == SRS_STAB) && (seq_r == 13'(STAB_CYC - 1)) && !pwr_start // RULE_09
		|=> (st_r == SRS_IEXT) && rst_pin_oe_b && internal_reset) else $error("stabilisation end wrong");
	a_stab_clk_off: assert property ((st_r == SRS_STAB) |-> !per_clk_en && !cpu_clk_en) // RULE_02
		else $error("clock enable during stabilisation");
	a_pin_flag_hold: assert property (!cause_r[F_PIN] && (st_r != SRS_EXTP) |=> !cause_r[F_PIN]) // RULE_07
		else $error("pin flag set outside pin reset");
	a_lvi_flag: assert property (uv_trip && !por_pulse |=> cause_r[F_LVI]) // RULE_19
		else $error("undervoltage flag not set");
	a_opc_flag: assert property (s_idle_int ##0 opc_bad |=> cause_r[F_OPC]) // RULE_16
		else $error("bad opcode flag not set");
	a_blk_force: assert property (s_idle_int ##0 blk_bad |=> force_monitor) // RULE_18
		else $error("monitor not forced after blank vector");
	a_vec_mon: assert property (force_monitor |-> reset_vector == VEC_HI_MON) // RULE_18
		else $error("forced monitor vector wrong");
	a_ext_count: assert property ((st_r == SRS_EXTP) && !pwr_start // RULE_05
		|=> sys_count == 13'($past(sys_count) + 13'h1)) else $error("pin reset touched counter");
	a_data_fetch: assert property ((st_r == SRS_IDLE) && !cpu.opfetch && !cpu.vecfetch // RULE_17
		&& !wdg_bad && !pwr_start && !pin_start |=> !internal_reset) else $error("reset without source");
endmodule

// ===== srs_pkg.sv
// Package of constants and types for the system reset and clock sequencer.
package srs_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned STAB_CYC = 4096;
	localparam int unsigned PIN_DRV_CYC = 32;
	localparam int unsigned INTERNAL_RESET_EXT_CYC = 32;
	localparam int unsigned POR_REL_CYC = 64;
	localparam int unsigned PIN_QUAL_CYC = 67;
	localparam int unsigned LVI_CPU_CYC = 9;
	localparam int unsigned BUS_DIV = 4;
	localparam int unsigned SCNT_W = 13;
	localparam int unsigned WDG_W = 8;
	localparam logic [SCNT_W-1:0] SCNT_SVC_MASK = 13'h000F;
	localparam logic [15:0] VEC_HI_USER = 16'hFFFE;
	localparam logic [15:0] VEC_HI_MON = 16'hFEFE;
	localparam logic [15:0] WDG_SVC_ADDR = 16'hFFFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [3:0] REG_CAUSE = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam int unsigned F_POR = 7;
	localparam int unsigned F_PIN = 6;
	localparam int unsigned F_WDG = 5;
	localparam int unsigned F_OPC = 4;
	localparam int unsigned F_ADR = 3;
	localparam int unsigned F_BLK = 2;
	localparam int unsigned F_LVI = 1;
	localparam logic [7:0] CAUSE_RST = 8'h80;
	typedef enum logic [2:0] {SRS_IDLE, SRS_STAB, SRS_PDRV, SRS_IEXT, SRS_EXTP} srs_state_e;
	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] data;
		logic wr;
		logic opfetch;
		logic vecfetch;
		logic illegal_op;
		logic stop_op;
		logic wait_mode;
		logic mapped;
	} srs_cpu_s;
endpackage

// ===== srs_cnt.sv
// Counter with clear, partial clear and terminal pulse.
`timescale 1ns/1ps
module srs_cnt #(
	parameter int unsigned W = 13
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic en,
	input wire logic clr,
	input wire logic [W-1:0] keep_mask,
	input wire logic pclr,
	output logic [W-1:0] cnt,
	output logic wrap
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	assign cnt_nxt = clr ? '0 : pclr ? (cnt_r & keep_mask) : en ? cnt_r + 1'b1 : cnt_r;
	assign wrap = en && !clr && !pclr && (&cnt_r);
	assign cnt = cnt_r;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end
endmodule

// ===== srs_far_model.sv
// Far-side model of the reset pin: pull-up, device pull-down and an outside pull-down.
`timescale 1ns/1ps
module srs_far_model (
	input wire logic rst_pin_oe_b,
	input wire logic rst_pin_o,
	input wire logic ext_pull,
	output logic rst_pin_i
);
	// The pin idles high by its pull-up; either party may pull it low at any time.
	assign rst_pin_i = (rst_pin_oe_b | rst_pin_o) & ~ext_pull;
endmodule

// ===== test_srs_top.sv
// Self-checking testbench of the system reset and clock sequencer.
`timescale 1ns/1ps
module test_srs_top;
	import srs_pkg::*;
	logic clk = 0, rst_b = 0, por_pulse = 0, uv_low = 0, wdg_timeout = 0, ext_pull = 0;
	logic pll_sel = 0, pll_clk_en = 1, hv_rst_pin = 0, hv_irq_pin = 0, mon_mode = 0;
	logic break_state = 0, big_part = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	srs_cpu_s cpu_in = '{mapped: 1'b1, default: '0};
	wire logic rst_pin_i, rst_pin_o, rst_pin_oe_b, internal_reset, cpu_clk_en, per_clk_en;
	wire logic clk_gen_en, force_monitor, wdg_disable;
	wire logic [15:0] reset_vector;
	wire logic [12:0] sys_count;
	wire logic [7:0] reg_rdata;
	logic [7:0] q[$];
	int mismatches = 0, samples_checked = 0, cyc = 0, np, ni, k;
	logic [31:0] rs = 32'h5FD89435;
	logic [12:0] s0;
	int fl[7] = '{F_OPC, F_OPC, F_ADR, F_BLK, F_WDG, F_LVI, F_POR};
	int ep[7] = '{32, 32, 32, 32, 32, 4096, 4096};
	int ei[7] = '{64, 64, 64, 64, 64, 4160, 4160};
	srs_far_model i_far (.rst_pin_oe_b(rst_pin_oe_b), .rst_pin_o(rst_pin_o),
		.ext_pull(ext_pull), .rst_pin_i(rst_pin_i));
	srs_top i_dut (.clk(clk), .rst_b(rst_b), .por_pulse(por_pulse), .uv_low(uv_low),
		.wdg_timeout(wdg_timeout), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
		.rst_pin_oe_b(rst_pin_oe_b), .pll_sel(pll_sel), .pll_clk_en(pll_clk_en),
		.hv_rst_pin(hv_rst_pin), .hv_irq_pin(hv_irq_pin), .mon_mode(mon_mode),
		.break_state(break_state), .big_part(big_part), .cpu(cpu_in),
		.internal_reset(internal_reset), .cpu_clk_en(cpu_clk_en), .per_clk_en(per_clk_en),
		.clk_gen_en(clk_gen_en), .force_monitor(force_monitor), .reset_vector(reset_vector),
		.wdg_disable(wdg_disable), .sys_count(sys_count), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	always #2 clk = ~clk;
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task automatic chk(input logic [15:0] a, input logic [15:0] e);
		samples_checked++;
		if (a !== e)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic conclude();
		$display("counts: %0d checked, %0d mismatches", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// A read result is compared one cycle after its strobe against the oldest note.
	always @(posedge clk)
	begin
		rd_d <= reg_rd;
		// The second source ticks on every other cycle while it is selected.
		pll_clk_en <= pll_sel ? ~pll_clk_en : 1'b1;
		if (rd_d)
			chk({8'h00, reg_rdata}, {8'h00, q.pop_front()});
		cyc++;
		if (cyc == 30000)
		begin
			mismatches++;
			conclude();
		end
	end
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		reg_wdata <= 8'(rnd());
		q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_idle();
		k = 0;
		repeat (8) @(negedge clk);
		while ((internal_reset !== 1'b0 || rst_pin_oe_b !== 1'b1) && k < 5000)
		begin
			@(negedge clk);
			k++;
		end
		chk(16'(k < 5000), 16'h0001);
	endtask
	task automatic count_en();
		np = 0;
		ni = 0;
		repeat (40)
		begin
			@(negedge clk);
			np += int'(cpu_clk_en === 1'b1);
			ni += int'(per_clk_en === 1'b1);
		end
	endtask
	task automatic set_src(input int i, input logic v);
		case (i)
			0: {cpu_in.opfetch, cpu_in.illegal_op} <= {v, v};
			1: {cpu_in.opfetch, cpu_in.stop_op} <= {v, v};
			2: cpu_in.opfetch <= v;
			3: cpu_in.vecfetch <= v;
			4: wdg_timeout <= v;
			5: uv_low <= v;
			default: por_pulse <= v;
		endcase
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		wait_idle();
		chk({15'h0000, clk_gen_en}, 16'h0001);
		rd(REG_CAUSE, CAUSE_RST);
		rd(REG_CAUSE, 8'h00);
		rd(4'hF, 8'h00);
		$display("test power-on done");
		count_en();
		chk(16'(np), 16'd10);
		@(posedge clk);
		cpu_in.wait_mode <= 1'b1;
		pll_sel <= 1'b1;
		count_en();
		chk(16'(np), 16'd0);
		chk(16'(ni), 16'd5);
		@(posedge clk);
		cpu_in.wait_mode <= 1'b0;
		$display("test bus clocks done");
		for (int m = 0; m < 16; m++)
		begin
			@(posedge clk);
			{hv_rst_pin, hv_irq_pin, mon_mode, break_state} <= 4'(m);
			@(negedge clk);
			chk({15'h0000, wdg_disable}, {15'h0000, mon_mode & (hv_rst_pin | hv_irq_pin)
				| break_state & hv_rst_pin});
			chk(reset_vector, mon_mode ? VEC_HI_MON : VEC_HI_USER);
		end
		@(posedge clk);
		{hv_rst_pin, hv_irq_pin, mon_mode, break_state} <= 4'h0;
		cpu_in.addr <= WDG_SVC_ADDR;
		cpu_in.wr <= 1'b1;
		cpu_in.mapped <= 1'b0;
		cpu_in.data <= 8'(rnd());
		@(posedge clk);
		cpu_in.wr <= 1'b0;
		@(negedge clk);
		chk(16'(sys_count < 13'd32), 16'h0001);
		repeat (10) @(negedge clk);
		chk({15'h0000, internal_reset}, 16'h0000);
		rd(REG_STAT, 8'h00);
		cpu_in.mapped <= 1'b1;
		$display("test watchdog service done");
		for (int j = 0; j < 2; j++)
		begin
			@(posedge clk);
			ext_pull <= 1'b1;
			@(negedge clk);
			s0 = sys_count;
			repeat (j ? 100 : 20) @(negedge clk);
			chk({3'h0, sys_count}, {3'h0, 13'(s0 + (j ? 13'd100 : 13'd20))});
			@(posedge clk);
			ext_pull <= 1'b0;
			wait_idle();
			rd(REG_CAUSE, j ? 8'(1 << F_PIN) : 8'h00);
		end
		$display("test pin reset done");
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clk);
			cpu_in.mapped <= (i != 2);
			big_part <= (i == 1);
			cpu_in.data <= ERASED_BYTE;
			set_src(i, 1'b1);
			if (i == 6)
			begin
				@(posedge clk);
				set_src(i, 1'b0);
			end
			k = 0;
			@(negedge clk);
			while (rst_pin_oe_b !== 1'b0 && internal_reset !== 1'b1 && k < 200)
			begin
				@(negedge clk);
				k++;
			end
			np = 0;
			ni = 0;
			k = 0;
			while ((rst_pin_oe_b === 1'b0 || internal_reset === 1'b1) && k < 5000)
			begin
				np += int'(rst_pin_oe_b === 1'b0);
				ni += int'(internal_reset === 1'b1);
				@(posedge clk) set_src(i, 1'b0);
				@(negedge clk);
				k++;
			end
			chk(16'(np), 16'(ep[i]));
			chk(16'(ni), 16'(ei[i]));
			wait_idle();
			rd(REG_CAUSE, 8'(1 << fl[i]));
			if (i == 3)
			begin
				rd(REG_CTRL, 8'h01);
				chk({15'h0000, force_monitor}, 16'h0001);
				chk(reset_vector, VEC_HI_MON);
			end
			if (i == 4)
				rd(REG_STAT, 8'h00);
			$display("test reset source %0d done", i);
		end
		conclude();
	end
endmodule
